// [bfp_pkg.sv]
// package for the breaker failure pick-up block
package bfp_pkg;

  // ----------------------------------------------------------------
  // measurement format
  // ----------------------------------------------------------------
  // magnitudes and thresholds in units of 0.001 x nominal current
  localparam int unsigned MAG_W          = 16;
  localparam logic [15:0] PH_THR_DEFAULT = 16'h00C8;  // 0.200 x nominal
  localparam logic [15:0] PH_THR_MIN     = 16'h000A;  // 0.010 x nominal
  localparam logic [15:0] PH_THR_MAX     = 16'h9C40;  // 40.000 x nominal
  localparam logic [15:0] RES_THR_DEFAULT = 16'h04B0; // 1.200 x nominal
  localparam logic [15:0] RES_THR_MIN    = 16'h0005;  // 0.005 x nominal
  localparam logic [15:0] RES_THR_MAX    = 16'h9C40;  // 40.000 x nominal
  // release ratio 97 % as a fraction of 100
  localparam logic [6:0]  RELEASE_PCT    = 7'h61;     // 97
  localparam logic [6:0]  FULL_PCT       = 7'h64;     // 100
  localparam int unsigned N_SIG          = 16;        // trip signal inputs
  localparam int unsigned N_RELAY        = 8;         // output relay states

  // ----------------------------------------------------------------
  // selections
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BFP_RES_OFF  = 2'b00,
    BFP_RES_ONE  = 2'b01,
    BFP_RES_TWO  = 2'b10,
    BFP_RES_CALC = 2'b11
  } bfp_res_sel_t;

  // operating modes; bits 3:0 index the table
  typedef enum logic [3:0] {
    BFP_M_CUR          = 4'h0,
    BFP_M_DO           = 4'h1,
    BFP_M_SIG          = 4'h2,
    BFP_M_CUR_AND_DO   = 4'h3,
    BFP_M_CUR_AND_SIG  = 4'h4,
    BFP_M_CUR_OR_SIG   = 4'h5,
    BFP_M_SIG_AND_DO   = 4'h6,
    BFP_M_SIG_OR_DO    = 4'h7,
    BFP_M_CUR_OR_DO    = 4'h8,
    BFP_M_CUR_OR_SIG_OR_DO   = 4'h9,
    BFP_M_CUR_AND_SIG_AND_DO = 4'hA
  } bfp_mode_t;

  typedef enum logic [2:0] {
    BFP_F_NORMAL  = 3'b000,
    BFP_F_START   = 3'b001,
    BFP_F_RETRIP  = 3'b010,
    BFP_F_FAILURE = 3'b011,
    BFP_F_BLOCKED = 3'b100
  } bfp_force_t;

  typedef enum logic [1:0] {
    BFP_S_NORMAL  = 2'b00,
    BFP_S_START   = 2'b01,
    BFP_S_BLOCKED = 2'b10
  } bfp_state_t;

  // fundamental-frequency magnitudes from the measurement front end
  typedef struct packed {
    logic [MAG_W-1:0] phase_a_current;
    logic [MAG_W-1:0] phase_b_current;
    logic [MAG_W-1:0] phase_c_current;
    logic [MAG_W-1:0] residual_input_one;
    logic [MAG_W-1:0] residual_input_two;
    logic [MAG_W-1:0] computed_residual;
  } bfp_meas_t;

  // static settings, outside the setting group
  typedef struct packed {
    bfp_res_sel_t           residual_source_select;
    bfp_mode_t              mode;
    logic [N_SIG-1:0]       sig_enable;
    logic [N_RELAY-1:0]     relay_enable;
    bfp_force_t             force_status;
  } bfp_static_t;

  // setting group values
  typedef struct packed {
    logic [MAG_W-1:0] phase_threshold;
    logic [MAG_W-1:0] residual_threshold;
  } bfp_group_t;

  // status outputs
  typedef struct packed {
    logic start;
    logic retrip;
    logic failure;
    logic blocked;
  } bfp_status_t;

endpackage

// [bfp_pickup.sv]
// breaker failure pick-up and trigger selection
`timescale 1ns/10ps

module bfp_pickup (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  cycle_tick_i,
  input  wire bfp_pkg::bfp_meas_t    meas_i,
  input  wire bfp_pkg::bfp_static_t  static_cfg_i,
  input  wire bfp_pkg::bfp_group_t   group_cfg_i,
  input  wire logic                  force_enable_i,
  input  wire logic                  block_i,
  input  wire logic [15:0]           trip_signals_i,
  input  wire logic [7:0]            relay_states_i,
  input  wire logic                  retrip_done_i,
  input  wire logic                  failure_done_i,
  output logic                       timer_start_o,
  output logic                       pickup_o,
  output bfp_pkg::bfp_status_t       status_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // magnitude times 100 versus threshold times pct, no truncation
  function automatic logic above_pct(input logic [15:0] mag,
                                     input logic [15:0] thr,
                                     input logic [6:0]  pct);
    logic [22:0] lhs;
    logic [22:0] rhs;
    lhs = 23'(mag) * 23'(bfp_pkg::FULL_PCT);
    rhs = 23'(thr) * 23'(pct);
    return lhs > rhs;
  endfunction

  // magnitude times 100 below threshold times pct, full width products
  function automatic logic below_pct(input logic [15:0] mag,
                                     input logic [15:0] thr,
                                     input logic [6:0]  pct);
    logic [22:0] lhs;
    logic [22:0] rhs;
    lhs = 23'(mag) * 23'(bfp_pkg::FULL_PCT);
    rhs = 23'(thr) * 23'(pct);
    return lhs < rhs;
  endfunction

  // hysteresis comparator: set above threshold, hold until below 97 %
  function automatic logic hyst(input logic [15:0] mag,
                                input logic [15:0] thr,
                                input logic        held);
    return above_pct(mag, thr, bfp_pkg::FULL_PCT) ||
           (held && !below_pct(mag, thr, bfp_pkg::RELEASE_PCT));
  endfunction

  // clamp a threshold into its settable range
  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ----------------------------------------------------------------
  // thresholds and residual selection
  // ----------------------------------------------------------------
  // group values read live each cycle
  wire logic [15:0] ph_thr  = clamp(group_cfg_i.phase_threshold,
                                    bfp_pkg::PH_THR_MIN, bfp_pkg::PH_THR_MAX);
  wire logic [15:0] res_thr = clamp(group_cfg_i.residual_threshold,
                                    bfp_pkg::RES_THR_MIN, bfp_pkg::RES_THR_MAX);

  wire logic [15:0] res_mag =
    (static_cfg_i.residual_source_select == bfp_pkg::BFP_RES_ONE) ?
      meas_i.residual_input_one :
    (static_cfg_i.residual_source_select == bfp_pkg::BFP_RES_TWO) ?
      meas_i.residual_input_two :
    (static_cfg_i.residual_source_select == bfp_pkg::BFP_RES_CALC) ?
      meas_i.computed_residual : 16'h0000;
  wire logic        res_used =
    static_cfg_i.residual_source_select != bfp_pkg::BFP_RES_OFF;

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  logic [2:0] ph_pu_q;
  logic [2:0] ph_pu_d;
  logic [2:0] ph_cmp;
  logic       res_pu_q;
  logic       res_pu_d;
  logic       res_cmp;

  // three phases against the shared threshold
  assign ph_cmp[0] = hyst(meas_i.phase_a_current, ph_thr, ph_pu_q[0]);
  assign ph_cmp[1] = hyst(meas_i.phase_b_current, ph_thr, ph_pu_q[1]);
  assign ph_cmp[2] = hyst(meas_i.phase_c_current, ph_thr, ph_pu_q[2]);
  assign res_cmp = res_used && hyst(res_mag, res_thr, res_pu_q);
  // comparators move only on a program-cycle strobe
  assign ph_pu_d  = cycle_tick_i ? ph_cmp : ph_pu_q;
  assign res_pu_d = cycle_tick_i ? res_cmp : res_pu_q;

  // comparator state, next value already holds between strobes
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ph_pu_q  <= 3'h0;
      res_pu_q <= 1'b0;
    end else begin
      ph_pu_q  <= ph_pu_d;
      res_pu_q <= res_pu_d;
    end
  end

  // ----------------------------------------------------------------
  // source combination
  // ----------------------------------------------------------------
  // any phase picks up
  // current clears when all below release
  wire logic cur_src = (|ph_pu_q) || res_pu_q;
  wire logic sig_src = |(trip_signals_i & static_cfg_i.sig_enable);
  wire logic do_src  = |(relay_states_i & static_cfg_i.relay_enable);

  logic src_pu;
  always_comb begin
    unique case (static_cfg_i.mode)
      bfp_pkg::BFP_M_CUR:                src_pu = cur_src;
      bfp_pkg::BFP_M_DO:                 src_pu = do_src;
      bfp_pkg::BFP_M_SIG:                src_pu = sig_src;
      bfp_pkg::BFP_M_CUR_AND_DO:         src_pu = cur_src && do_src;
      bfp_pkg::BFP_M_CUR_AND_SIG:        src_pu = cur_src && sig_src;
      bfp_pkg::BFP_M_CUR_OR_SIG:         src_pu = cur_src || sig_src;
      bfp_pkg::BFP_M_SIG_AND_DO:         src_pu = sig_src && do_src;
      bfp_pkg::BFP_M_SIG_OR_DO:          src_pu = sig_src || do_src;
      bfp_pkg::BFP_M_CUR_OR_DO:          src_pu = cur_src || do_src;
      bfp_pkg::BFP_M_CUR_OR_SIG_OR_DO:   src_pu = cur_src || sig_src || do_src;
      bfp_pkg::BFP_M_CUR_AND_SIG_AND_DO: src_pu = cur_src && sig_src && do_src;
      default:                           src_pu = cur_src; // illegal code
    endcase
  end

  // ----------------------------------------------------------------
  // start / blocked state
  // ----------------------------------------------------------------
  bfp_pkg::bfp_state_t state_q;
  bfp_pkg::bfp_state_t state_d;

  // block at pick-up and during start
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bfp_pkg::BFP_S_NORMAL:
        if (src_pu) begin
          state_d = block_i ? bfp_pkg::BFP_S_BLOCKED : bfp_pkg::BFP_S_START;
        end
      bfp_pkg::BFP_S_START:
        if (!src_pu || block_i) begin
          state_d = (src_pu && block_i) ? bfp_pkg::BFP_S_BLOCKED : bfp_pkg::BFP_S_NORMAL;
        end
      bfp_pkg::BFP_S_BLOCKED:
        if (!src_pu) begin
          state_d = bfp_pkg::BFP_S_NORMAL;
        end else if (!block_i) begin
          state_d = bfp_pkg::BFP_S_START;
        end
      default: state_d = bfp_pkg::BFP_S_NORMAL;
    endcase
    // state only moves on a program-cycle strobe
    if (!cycle_tick_i) begin
      state_d = state_q;
    end
  end

  // state register, block checked at the start of each program cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= bfp_pkg::BFP_S_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // static force setting applied directly
  wire logic          forcing = force_enable_i &&
                                (static_cfg_i.force_status != bfp_pkg::BFP_F_NORMAL);
  bfp_pkg::bfp_status_t status_d;
  always_comb begin
    status_d.start   = state_q == bfp_pkg::BFP_S_START;
    status_d.retrip  = status_d.start && retrip_done_i;
    status_d.failure = status_d.start && failure_done_i;
    status_d.blocked = state_q == bfp_pkg::BFP_S_BLOCKED;
    if (forcing) begin
      status_d.start   = static_cfg_i.force_status != bfp_pkg::BFP_F_BLOCKED;
      status_d.retrip  = static_cfg_i.force_status == bfp_pkg::BFP_F_RETRIP;
      status_d.failure = static_cfg_i.force_status == bfp_pkg::BFP_F_FAILURE;
      status_d.blocked = static_cfg_i.force_status == bfp_pkg::BFP_F_BLOCKED;
    end
  end

  // registered outputs
  // one start level for both timers, high for as long as start is set
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_o      <= '0;
      pickup_o      <= 1'b0;
      timer_start_o <= 1'b0;
    end else begin
      status_o      <= status_d;
      pickup_o      <= src_pu;
      timer_start_o <= status_d.start;
    end
  end

endmodule

// [bfp_meas_model.sv]
// measurement front end model: program-cycle strobe and magnitudes
`timescale 1ns/10ps
module bfp_meas_model #(
  parameter int unsigned TICK_DIV = 4
) (
  input  wire logic               core_clk_i,
  input  wire logic               reset_n_i,
  input  wire bfp_pkg::bfp_meas_t meas_req_i,
  output logic                    cycle_tick_o,
  output bfp_pkg::bfp_meas_t      meas_o
);
  logic [7:0] div_q;
  // fundamental magnitudes only, refreshed once per program cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_q        <= 8'h00;
      cycle_tick_o <= 1'b0;
      meas_o       <= '0;
    end else begin
      div_q        <= (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
      cycle_tick_o <= (div_q == 8'(TICK_DIV - 1));
      if (div_q == 8'h00) meas_o <= meas_req_i;
    end
  end
endmodule

// [bfp_pickup_asserts.sv]
// checker for the breaker failure pick-up block
`timescale 1ns/10ps
module bfp_pickup_asserts (
  input wire logic                 core_clk_i,
  input wire logic                 reset_n_i,
  input wire logic                 cycle_tick_i,
  input wire bfp_pkg::bfp_meas_t   meas_i,
  input wire bfp_pkg::bfp_static_t static_cfg_i,
  input wire bfp_pkg::bfp_group_t  group_cfg_i,
  input wire logic                 force_enable_i,
  input wire logic                 block_i,
  input wire logic [15:0]          trip_signals_i,
  input wire logic [7:0]           relay_states_i,
  input wire logic                 retrip_done_i,
  input wire logic                 failure_done_i,
  input wire logic                 timer_start_o,
  input wire logic                 pickup_o,
  input wire bfp_pkg::bfp_status_t status_o
);
  bfp_pkg::bfp_mode_t md;
  logic [15:0]        thr;
  logic [31:0]        lim;
  logic               sig_hit, do_hit, ph_over, all_low;
  // source hits and phase comparisons
  assign md      = static_cfg_i.mode;
  assign thr     = group_cfg_i.phase_threshold;
  assign lim     = 32'(thr) * 32'h61;
  assign sig_hit = |(trip_signals_i & static_cfg_i.sig_enable);
  assign do_hit  = |(relay_states_i & static_cfg_i.relay_enable);
  assign ph_over = thr >= bfp_pkg::PH_THR_MIN && (meas_i.phase_a_current > thr
                   || meas_i.phase_b_current > thr || meas_i.phase_c_current > thr);
  assign all_low = 32'(meas_i.phase_a_current) * 32'h64 < lim
                   && 32'(meas_i.phase_b_current) * 32'h64 < lim
                   && 32'(meas_i.phase_c_current) * 32'h64 < lim
                   && static_cfg_i.residual_source_select == bfp_pkg::BFP_RES_OFF;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // quiet cycle in current mode, and a condition held three edges from a tick
  sequence cur_hold_s;
    (!cycle_tick_i && md == bfp_pkg::BFP_M_CUR) ##1 (md == bfp_pkg::BFP_M_CUR);
  endsequence
  sequence run3_s(c);
    cycle_tick_i ##0 (c)[*3];
  endsequence
  cur_rise_a:
  assert property (cycle_tick_i && ph_over && md == bfp_pkg::BFP_M_CUR ##1 cur_hold_s
    |-> pickup_o) else $error("phase over threshold without pick-up");
  cur_fall_a:
  assert property (cycle_tick_i && all_low && md == bfp_pkg::BFP_M_CUR ##1 cur_hold_s
    |-> !pickup_o) else $error("pick-up held below release level");
  sig_mode_a:
  assert property (run3_s(md == bfp_pkg::BFP_M_SIG && sig_hit) |-> pickup_o)
    else $error("enabled trip signal without pick-up");
  do_mode_a:
  assert property (run3_s(md == bfp_pkg::BFP_M_DO && do_hit) |-> pickup_o)
    else $error("enabled relay state without pick-up");
  and_mode_a:
  assert property (run3_s(md == bfp_pkg::BFP_M_SIG_AND_DO && sig_hit && !do_hit)
    |-> !pickup_o) else $error("and mode picked up on one source");
  force_block_a:
  assert property (run3_s(force_enable_i
    && static_cfg_i.force_status == bfp_pkg::BFP_F_BLOCKED) |-> status_o.blocked)
    else $error("forced blocked not shown");
  blocked_excl_a:
  assert property (status_o.blocked |-> !status_o.start) else $error("blocked with start");
  start_timer_a:
  assert property ($rose(status_o.start) && !force_enable_i
    |-> $past(pickup_o) && timer_start_o) else $error("start without pick-up or timers");
endmodule

// [bfp_pickup_tb_top.sv]
// testbench for the breaker failure pick-up block
`timescale 1ns/10ps
module bfp_pickup_tb_top;
  logic                 core_clk_i = 1'b0;
  logic                 reset_n_i  = 1'b0;
  logic                 cycle_tick_i, timer_start, pickup;
  logic                 force_enable_i = 1'b0;
  logic                 block_i        = 1'b0;
  logic                 retrip_done    = 1'b0;
  logic                 failure_done   = 1'b0;
  logic [15:0]          trip = 16'h0000;
  logic [7:0]           rel  = 8'h00;
  bfp_pkg::bfp_meas_t   mq = '0;
  bfp_pkg::bfp_meas_t   meas;
  bfp_pkg::bfp_static_t sc = '{bfp_pkg::BFP_RES_OFF, bfp_pkg::BFP_M_CUR, 16'h0100,
                             8'h04, bfp_pkg::BFP_F_NORMAL};
  bfp_pkg::bfp_group_t  gc = '{bfp_pkg::PH_THR_DEFAULT, bfp_pkg::RES_THR_DEFAULT};
  bfp_pkg::bfp_status_t status;
  int                   fails = 0, checks_done = 0, cyc = 0;
  // source truth table per mode, index {current, signal, relay}
  localparam logic [10:0][7:0] TT = {8'h80, 8'hFE, 8'hFA, 8'hEE, 8'h88, 8'hFC,
                                     8'hC0, 8'hA0, 8'hCC, 8'hAA, 8'hF0};
  localparam logic [2:0][3:0]  FX = {4'h1, 4'hA, 4'hC};

  always #12.5 core_clk_i = ~core_clk_i;

  bfp_meas_model u_src (.core_clk_i, .reset_n_i, .meas_req_i(mq),
                        .cycle_tick_o(cycle_tick_i), .meas_o(meas));
  bfp_pickup dut (.core_clk_i, .reset_n_i, .cycle_tick_i, .meas_i(meas), .static_cfg_i(sc),
                  .group_cfg_i(gc), .force_enable_i, .block_i, .trip_signals_i(trip),
                  .relay_states_i(rel), .retrip_done_i(retrip_done),
                  .failure_done_i(failure_done),
                  .timer_start_o(timer_start), .pickup_o(pickup), .status_o(status));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // status with the timer start, which follows start
  task automatic chk_stat(input logic [3:0] exp);
    checks_done++;
    if ({status, timer_start} !== {exp, exp[3]}) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, {status, timer_start}, {exp, exp[3]});
    end
  endtask
  // three program cycles, then the two-edge answer delay
  task automatic settle();
    repeat (3) begin
      do @(posedge core_clk_i); while (cycle_tick_i !== 1'b1);
    end
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      test_done();
    end
  end

  // main sequence
  initial begin
    repeat (8) @(posedge core_clk_i);
    #1;
    reset_n_i = 1'b1;
    settle();
    chk_stat(4'h0);
    for (int i = 0; i < 3; i++) begin
      mq = '0;
      mq[95-16*i -: 16] = 16'h00C9;
      settle();
      chk_bit(pickup, 1'b1);
      chk_stat(4'h8);
      mq = '0;
      settle();
      chk_bit(pickup, 1'b0);
    end
    gc.phase_threshold = 16'h03E8;
    mq.phase_a_current = 16'h03E9;
    settle();
    mq.phase_a_current = 16'h03CA;
    settle();
    chk_bit(pickup, 1'b1);
    mq.phase_a_current = 16'h03C9;
    settle();
    chk_bit(pickup, 1'b0);
    mq.phase_a_current = 16'h03E9;
    settle();
    gc.phase_threshold = 16'h07D0;
    settle();
    chk_bit(pickup, 1'b0);
    gc.phase_threshold = 16'h0001;
    mq.phase_a_current = 16'h0009;
    settle();
    chk_bit(pickup, 1'b0);
    gc.phase_threshold = bfp_pkg::PH_THR_DEFAULT;
    mq = '0;
    mq[47:0] = {3{16'h9C40}};
    settle();
    chk_bit(pickup, 1'b0);
    for (int r = 1; r < 4; r++) begin
      sc.residual_source_select = bfp_pkg::bfp_res_sel_t'(2'(r));
      mq[47:0] = {3{16'h9C40}};
      mq[63-16*r -: 16] = 16'h0000;
      settle();
      chk_bit(pickup, 1'b0);
      mq[47:0] = '0;
      mq[63-16*r -: 16] = 16'h04B1;
      settle();
      chk_bit(pickup, 1'b1);
    end
    gc.residual_threshold = 16'h0001;
    mq[15:0] = 16'h0004;
    settle();
    chk_bit(pickup, 1'b0);
    sc.residual_source_select = bfp_pkg::BFP_RES_OFF;
    mq = '0;
    for (int m = 0; m < 11; m++) begin
      for (int k = 0; k < 8; k++) begin
        sc.mode = bfp_pkg::bfp_mode_t'(4'(m));
        mq.phase_a_current = k[2] ? 16'h00C9 : 16'h0000;
        trip = k[1] ? 16'h0100 : 16'hFEFF;
        rel = k[0] ? 8'h04 : 8'hFB;
        settle();
        chk_bit(pickup, TT[m][k]);
        chk_stat({TT[m][k], 3'b000});
      end
    end
    sc.mode = bfp_pkg::BFP_M_CUR;
    mq = '0;
    settle();
    block_i = 1'b1;
    mq.phase_a_current = 16'h00C9;
    settle();
    chk_bit(pickup, 1'b1);
    chk_stat(4'h1);
    block_i = 1'b0;
    settle();
    chk_stat(4'h8);
    retrip_done = 1'b1;
    failure_done = 1'b1;
    settle();
    chk_stat(4'hE);
    retrip_done = 1'b0;
    failure_done = 1'b0;
    block_i = 1'b1;
    settle();
    chk_stat(4'h1);
    block_i = 1'b0;
    mq = '0;
    sc.force_status = bfp_pkg::BFP_F_START;
    settle();
    chk_stat(4'h0);
    force_enable_i = 1'b1;
    settle();
    chk_stat(4'h8);
    for (int f = 2; f < 5; f++) begin
      sc.force_status = bfp_pkg::bfp_force_t'(3'(f));
      settle();
      chk_stat(FX[f-2]);
    end
    sc.force_status = bfp_pkg::BFP_F_NORMAL;
    settle();
    chk_stat(4'h0);
    test_done();
  end
endmodule

bind bfp_pickup bfp_pickup_asserts u_chk (.core_clk_i, .reset_n_i, .cycle_tick_i, .meas_i,
  .static_cfg_i, .group_cfg_i, .force_enable_i, .block_i, .trip_signals_i, .relay_states_i,
  .retrip_done_i, .failure_done_i, .timer_start_o, .pickup_o, .status_o);
